// ---- shared/scp_pkg.sv ----
/*
  scp_pkg: constants and carrier types for the sensor parameter bank.
  assumes one 50 MHz clock domain and a command engine that decodes the
  serial link and issues one parameter command at a time.
*/
package scp_pkg;

  localparam int unsigned SCP_DEPTH = 32;
  localparam int unsigned SCP_AW = 5;

  // entry offsets
  localparam logic [7:0] SCP_OFS_BUS_ADDR = 8'h00;
  localparam logic [7:0] SCP_OFS_CHAN_LIST = 8'h01;
  localparam logic [7:0] SCP_OFS_LED_SEL12 = 8'h02;
  localparam logic [7:0] SCP_OFS_LED_SEL3 = 8'h03;
  localparam logic [7:0] SCP_OFS_AMB_HIST = 8'h19;
  localparam logic [7:0] SCP_OFS_CONV_OFS = 8'h1a;
  localparam logic [7:0] SCP_OFS_RSVD_1B = 8'h1b;
  localparam logic [7:0] SCP_OFS_LED_RECOVERY_TIME = 8'h1c;
  localparam logic [7:0] SCP_OFS_IR_REC = 8'h1d;
  localparam logic [7:0] SCP_OFS_IR_GAIN = 8'h1e;
  localparam logic [7:0] SCP_OFS_IR_MISC = 8'h1f;

  // reset values
  localparam logic [7:0] SCP_RST_BUS_ADDR = 8'h00;
  localparam logic [7:0] SCP_RST_CHAN_LIST = 8'h00;
  localparam logic [7:0] SCP_RST_LED_SEL12 = 8'h21;
  localparam logic [7:0] SCP_RST_LED_SEL3 = 8'h04;
  localparam logic [7:0] SCP_RST_OTHER = 8'h00;

  // writable bits per entry; reserved bits store and read as zero
  localparam logic [7:0] SCP_MSK_CHAN_LIST = 8'h77;
  localparam logic [7:0] SCP_MSK_LED_SEL12 = 8'h77;
  localparam logic [7:0] SCP_MSK_LED_SEL3 = 8'h07;
  localparam logic [7:0] SCP_MSK_RSVD = 8'h00;
  localparam logic [7:0] SCP_MSK_FULL = 8'hff;

  // field positions
  localparam int unsigned SCP_BIT_AUX = 6;
  localparam int unsigned SCP_BIT_AMB_IR = 5;
  localparam int unsigned SCP_BIT_AMB_VIS = 4;
  localparam int unsigned SCP_BIT_PROX3 = 2;
  localparam int unsigned SCP_BIT_PROX2 = 1;
  localparam int unsigned SCP_BIT_PROX1 = 0;
  localparam int unsigned SCP_LSB_LED_LO = 0;
  localparam int unsigned SCP_LSB_LED_HI = 4;

  typedef enum logic [1:0] {
    SCP_OP_NONE = 2'h0,
    SCP_OP_READ = 2'h1,
    SCP_OP_WRITE = 2'h2,
    SCP_OP_ADOPT = 2'h3
  } scp_op_e;

  typedef struct packed {
    scp_op_e op;
    logic [7:0] offset;
    logic [7:0] data;
  } scp_cmd_s;

  typedef struct packed {
    logic aux_enable;
    logic ambient_ir_enable;
    logic ambient_visible_enable;
    logic prox_three_enable;
    logic prox_two_enable;
    logic prox_one_enable;
  } scp_chan_s;

  typedef struct packed {
    logic [2:0] prox_three_led_field;
    logic [2:0] prox_two_led_field;
    logic [2:0] prox_one_led_field;
  } scp_led_s;

endpackage

// ---- test/scp_host_model.sv ----
/*
  scp_host_model: host side of the parameter command port.
  assumes calls come 1 ns after a rising edge of i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
  input wire logic i_clk,
  input wire logic i_rsp_valid,
  input wire logic [7:0] i_rsp_data,
  output logic o_cmd_valid,
  output scp_pkg::scp_cmd_s o_cmd
);
  import scp_pkg::*;
  int gap = 0; // idle cycles after a command, 0 = back to back
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
  end
  // entries reached only through read and write commands
  // no measurement is ever requested here, so no list precondition
  task automatic send(input scp_op_e op, input logic [7:0] ofs,
      input logic [7:0] dat, output logic rv, output logic [7:0] rd);
    o_cmd_valid = 1'b1;
    o_cmd = {op, ofs, dat};
    @(posedge i_clk);
    #1;
    rv = i_rsp_valid;
    rd = i_rsp_data;
    repeat (gap) idle();
  endtask
  // released lines show the inverse so a stale value never matches
  task automatic idle();
    o_cmd_valid = 1'b0;
    o_cmd.offset = ~o_cmd.offset;
    o_cmd.data = ~o_cmd.data;
    @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- test/sensor_channel_led_param_bank_bench.sv ----
/*
  sensor_channel_led_param_bank_bench: self-checking bench of the bank.
  assumes the host model drives the command port.
*/
`timescale 1ns/1ps
`default_nettype none
module sensor_channel_led_param_bank_bench;
  import scp_pkg::*;
  localparam logic [7:0] BOOT = 8'h3c;
  logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, cmd_valid, rsp_valid;
  logic meas_allowed, rv;
  logic [7:0] rsp_data, bus_address, rdat, ofs;
  logic [2:0] lv;
  logic [15:0] ev;
  logic [7:0] ex;
  scp_cmd_s cmd;
  scp_chan_s chan;
  scp_led_s led;
  int err_total = 0, total_checks = 0;
  int pos[6] = '{0, 1, 2, 4, 5, 6};
  always #10 clk = ~clk;
  scp_param_bank #(.BOOT_BUS_ADDR(BOOT)) DUT (.i_clk(clk),
    .i_arst_n(arst_n), .i_ce(ce), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_bus_address(bus_address), .o_meas_allowed(meas_allowed),
    .o_chan(chan), .o_led(led));
  scp_host_model HOST (.i_clk(clk), .i_rsp_valid(rsp_valid),
    .i_rsp_data(rsp_data), .o_cmd_valid(cmd_valid), .o_cmd(cmd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input scp_op_e op, input logic [7:0] o,
      input logic [7:0] dat, input logic [7:0] exp);
    HOST.send(op, o, dat, rv, rdat);
    chk({7'h0, rv, rdat}, {8'h01, exp});
  endtask
  task automatic chk_reset();
    chk({8'h0, bus_address}, {8'h0, BOOT});
    chk({7'h0, meas_allowed, 2'h0, chan}, 16'h0);
    chk({7'h0, led}, 16'h0111);
    xfer(SCP_OP_READ, 8'h00, 8'h00, 8'h00);
    xfer(SCP_OP_READ, 8'h01, 8'h00, 8'h00);
    xfer(SCP_OP_READ, 8'h02, 8'h00, 8'h21);
    xfer(SCP_OP_READ, 8'h03, 8'h00, 8'h04);
    xfer(SCP_OP_READ, 8'h1b, 8'h00, 8'h00);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    chk_reset();
    // one channel at a time; the list must be non-zero to measure
    for (int i = 0; i < 6; i++) begin
      xfer(SCP_OP_WRITE, 8'h01, 8'h01 << pos[i], 8'h00);
      ev = 16'h0100 | (16'h1 << i);
      chk({7'h0, meas_allowed, 2'h0, chan}, ev);
    end
    xfer(SCP_OP_WRITE, 8'h01, 8'hff, 8'h00);
    xfer(SCP_OP_READ, 8'h01, 8'h00, 8'h77);
    xfer(SCP_OP_WRITE, 8'h01, 8'h00, 8'h00);
    chk({15'h0, meas_allowed}, 16'h0);
    for (int v = 0; v < 8; v++) begin
      lv = 3'(v);
      xfer(SCP_OP_WRITE, 8'h02, {1'b0, lv, 1'b0, ~lv}, 8'h00);
      xfer(SCP_OP_WRITE, 8'h03, {5'h0, lv}, 8'h00);
      chk({7'h0, led}, {7'h0, lv, lv, ~lv});
    end
    xfer(SCP_OP_READ, 8'h02, 8'h00, 8'h70);
    xfer(SCP_OP_READ, 8'h03, 8'h00, 8'h07);
    // slow host: the stored address must not take effect on its own
    HOST.gap = 2;
    xfer(SCP_OP_WRITE, 8'h00, 8'h55, 8'h00);
    chk({8'h0, bus_address}, {8'h0, BOOT});
    HOST.gap = 0;
    xfer(SCP_OP_WRITE, 8'h00, 8'ha6, 8'h00);
    xfer(SCP_OP_ADOPT, 8'h00, 8'h00, 8'h00);
    chk({8'h0, bus_address}, 16'h00a6);
    xfer(SCP_OP_READ, 8'h00, 8'h00, 8'ha6);
    for (int o = 8'h19; o <= 8'h20; o++) begin
      ofs = 8'(o);
      xfer(SCP_OP_WRITE, ofs, ofs ^ 8'ha5, 8'h00);
    end
    for (int o = 8'h19; o <= 8'h20; o++) begin
      ofs = 8'(o);
      ex = (o == 8'h1b || o == 8'h20) ? 8'h00 : ofs ^ 8'ha5;
      xfer(SCP_OP_READ, ofs, 8'h00, ex);
    end
    // read straight after write of the same entry
    xfer(SCP_OP_WRITE, 8'h19, 8'h3c, 8'h00);
    xfer(SCP_OP_READ, 8'h19, 8'h00, 8'h3c);
    // an empty command gives no answer
    HOST.send(SCP_OP_NONE, 8'h19, 8'h00, rv, rdat);
    chk({15'h0, rv}, 16'h0);
    // a frozen bank takes no command and gives no answer
    HOST.idle();
    ce = 1'b0;
    HOST.send(SCP_OP_WRITE, 8'h1c, 8'h00, rv, rdat);
    chk({15'h0, rv}, 16'h0);
    HOST.idle();
    ce = 1'b1;
    xfer(SCP_OP_READ, 8'h1c, 8'h00, 8'hb9);
    HOST.idle();
    arst_n = 1'b0;
    HOST.idle();
    chk({15'h0, rsp_valid}, 16'h0);
    arst_n = 1'b1;
    chk_reset();
    HOST.idle();
    finish_test();
  end
endmodule
`default_nettype wire

// ---- verilog/scp_param_bank.sv ----
/*
  scp_param_bank: indirectly addressed parameter memory of the sensor.
  assumes a command engine that hands over decoded read, write and
  adopt-address commands as one-cycle strobes, synchronous to i_clk.
*/
// What this block does
// R1: entries are reached only by parameter read and write commands.
// R2: the bus address changes only when the adopt command copies entry 0x00.
// R3: list bits 6, 5, 4 enable aux, ambient infrared and visible channels.
// R4: list bits 2, 1 and 0 enable proximity channels three, two and one.
// R5: the host writes a non-zero channel list before starting a measurement.
// R6: the address entry and the channel list reset to zero, no channel on.
// R7: first LED entry bits 2:0 pick LEDs for proximity one, 000 drives none.
// R8: first LED entry bits 6:4 pick LEDs for proximity two.
// R9: second LED entry bits 2:0 pick LEDs for proximity three.
// R10: field bit 0 drives LED one, bit 1 LED two, bit 2 LED three, any mix.
// R11: first LED entry resets to LED one for prox one, LED two for prox two.
// R12: the second LED entry resets to LED three for proximity three.
// R13: a read returns the last value written there with reserved bits zero, or the reset value.
`timescale 1ns/1ps
`default_nettype none
module scp_param_bank #(
  parameter logic [7:0] BOOT_BUS_ADDR = 8'h2a // arbitrary start address
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_cmd_valid,
  input wire scp_pkg::scp_cmd_s i_cmd,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  output logic [7:0] o_bus_address,
  output logic o_meas_allowed,
  output scp_pkg::scp_chan_s o_chan,
  output scp_pkg::scp_led_s o_led
);
  import scp_pkg::*;

  logic [7:0] mem_q [SCP_DEPTH];
  logic [7:0] mem_d [SCP_DEPTH];
  logic [7:0] addr_q, addr_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [7:0] rsp_data_q, rsp_data_d;
  logic allowed_q, allowed_d;
  logic take;
  logic in_range;
  logic [SCP_AW-1:0] idx;

  function automatic logic [7:0] rst_val(input int unsigned i);
    case (i)
      int'(SCP_OFS_BUS_ADDR): rst_val = SCP_RST_BUS_ADDR;
      int'(SCP_OFS_CHAN_LIST): rst_val = SCP_RST_CHAN_LIST;
      int'(SCP_OFS_LED_SEL12): rst_val = SCP_RST_LED_SEL12;
      int'(SCP_OFS_LED_SEL3): rst_val = SCP_RST_LED_SEL3;
      default: rst_val = SCP_RST_OTHER;
    endcase
  endfunction

  function automatic logic [7:0] wr_mask(input int unsigned i);
    case (i)
      int'(SCP_OFS_CHAN_LIST): wr_mask = SCP_MSK_CHAN_LIST;
      int'(SCP_OFS_LED_SEL12): wr_mask = SCP_MSK_LED_SEL12;
      int'(SCP_OFS_LED_SEL3): wr_mask = SCP_MSK_LED_SEL3;
      int'(SCP_OFS_RSVD_1B): wr_mask = SCP_MSK_RSVD;
      default: wr_mask = SCP_MSK_FULL;
    endcase
  endfunction

  // only the command port reaches the entries, there is no address map [R1]
  assign take = i_ce && i_cmd_valid;
  assign in_range = i_cmd.offset < 8'(SCP_DEPTH);
  assign idx = i_cmd.offset[SCP_AW-1:0];

  // one entry per generate step; unmapped offsets are ignored
  for (genvar g = 0; g < SCP_DEPTH; g++) begin : g_ent
    always_comb begin
      mem_d[g] = mem_q[g];
      if (take && in_range && i_cmd.op == SCP_OP_WRITE &&
          idx == SCP_AW'(g)) begin
        mem_d[g] = i_cmd.data & wr_mask(g); // [R13]
      end
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        mem_q[g] <= rst_val(g); // [R6] [R11] [R12]
      end else if (i_ce) begin
        mem_q[g] <= mem_d[g];
      end
    end
  end

  always_comb begin
    addr_d = addr_q;
    rsp_valid_d = take && i_cmd.op != SCP_OP_NONE;
    rsp_data_d = 8'h00;
    if (take && i_cmd.op == SCP_OP_READ && in_range) begin
      rsp_data_d = mem_q[idx]; // [R13]
    end
    // writing entry 0x00 alone never moves the live address [R2]
    if (take && i_cmd.op == SCP_OP_ADOPT) begin
      addr_d = mem_q[SCP_OFS_BUS_ADDR[SCP_AW-1:0]]; // [R2]
    end
    // flag from the next list value so the output stays a flop [R5]
    allowed_d = |mem_d[SCP_OFS_CHAN_LIST[SCP_AW-1:0]];
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_q <= BOOT_BUS_ADDR;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
      allowed_q <= 1'b0;
    end else if (i_ce) begin
      addr_q <= addr_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      allowed_q <= allowed_d;
    end
  end

  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_data = rsp_data_q;
  assign o_bus_address = addr_q;
  assign o_meas_allowed = allowed_q;

  // channel enables are bits of the stored list
  logic [7:0] chl;
  logic [7:0] l12;
  logic [7:0] l3;
  assign chl = mem_q[SCP_OFS_CHAN_LIST[SCP_AW-1:0]];
  assign l12 = mem_q[SCP_OFS_LED_SEL12[SCP_AW-1:0]];
  assign l3 = mem_q[SCP_OFS_LED_SEL3[SCP_AW-1:0]];
  assign o_chan.aux_enable = chl[SCP_BIT_AUX]; // [R3]
  assign o_chan.ambient_ir_enable = chl[SCP_BIT_AMB_IR]; // [R3]
  assign o_chan.ambient_visible_enable = chl[SCP_BIT_AMB_VIS]; // [R3]
  assign o_chan.prox_three_enable = chl[SCP_BIT_PROX3]; // [R4]
  assign o_chan.prox_two_enable = chl[SCP_BIT_PROX2]; // [R4]
  assign o_chan.prox_one_enable = chl[SCP_BIT_PROX1]; // [R4]
  // field bit n drives LED n+1; mixes pass straight through [R10]
  assign o_led.prox_one_led_field = l12[SCP_LSB_LED_LO +: 3]; // [R7]
  assign o_led.prox_two_led_field = l12[SCP_LSB_LED_HI +: 3]; // [R8]
  assign o_led.prox_three_led_field = l3[SCP_LSB_LED_LO +: 3]; // [R9]

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  logic fresh_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fresh_q <= 1'b1;
    end else if (i_ce && i_cmd_valid) begin
      fresh_q <= 1'b0;
    end
  end

  a_reset_zero_list: assert property ( // [R6]
    fresh_q |-> (chl == 8'h00 && o_chan == '0 && !o_meas_allowed &&
                 mem_q[0] == 8'h00))
    else $error("address or channel entry not zero after reset");
  a_reset_led12: assert property ( // [R11]
    fresh_q |-> l12 == 8'h21 && o_led.prox_one_led_field == 3'h1)
    else $error("first led entry reset value wrong");
  a_reset_led3: assert property ( // [R12]
    fresh_q |-> l3 == 8'h04 && o_led.prox_three_led_field == 3'h4)
    else $error("second led entry reset value wrong");
  a_addr_holds: assert property ( // [R2]
    !(i_ce && i_cmd_valid && i_cmd.op == SCP_OP_ADOPT)
      |=> $stable(o_bus_address))
    else $error("bus address moved without adopt command");
  a_addr_adopt: assert property ( // [R2]
    (i_ce && i_cmd_valid && i_cmd.op == SCP_OP_ADOPT)
      |=> o_bus_address == $past(mem_q[0]))
    else $error("adopt command did not load stored address");
  a_chan_bits: assert property ( // [R3]
    {o_chan.aux_enable, o_chan.ambient_ir_enable,
     o_chan.ambient_visible_enable} == chl[6:4])
    else $error("upper channel enables mismatch");
  a_prox_bits: assert property ( // [R4]
    {o_chan.prox_three_enable, o_chan.prox_two_enable,
     o_chan.prox_one_enable} == chl[2:0])
    else $error("proximity channel enables mismatch");
  // written bits must reach the enables one cycle later
  a_chan_write: assert property ( // [R3]
    (i_ce && i_cmd_valid && i_cmd.op == SCP_OP_WRITE &&
     i_cmd.offset == SCP_OFS_CHAN_LIST)
      |=> {o_chan.aux_enable, o_chan.ambient_ir_enable,
           o_chan.ambient_visible_enable} == $past(i_cmd.data[6:4]))
    else $error("upper channel enables do not follow write");
  a_prox_write: assert property ( // [R4]
    (i_ce && i_cmd_valid && i_cmd.op == SCP_OP_WRITE &&
     i_cmd.offset == SCP_OFS_CHAN_LIST)
      |=> {o_chan.prox_three_enable, o_chan.prox_two_enable,
           o_chan.prox_one_enable} == $past(i_cmd.data[2:0]))
    else $error("proximity enables do not follow write");
  a_led_fields: assert property ( // [R7]
    (i_ce && i_cmd_valid && i_cmd.op == SCP_OP_WRITE &&
     i_cmd.offset == 8'h02)
      |=> o_led.prox_one_led_field == $past(i_cmd.data[2:0]) &&
          o_led.prox_two_led_field == $past(i_cmd.data[6:4])) // [R8]
    else $error("first led entry write not reflected");
  a_led3_field: assert property ( // [R9]
    (i_ce && i_cmd_valid && i_cmd.op == SCP_OP_WRITE &&
     i_cmd.offset == 8'h03)
      |=> o_led.prox_three_led_field == $past(i_cmd.data[2:0]))
    else $error("second led entry write not reflected");
  a_write_read: assert property ( // [R13]
    (i_ce && i_cmd_valid && i_cmd.op == SCP_OP_WRITE &&
     i_cmd.offset == 8'h19)
      ##1 (i_ce && i_cmd_valid && i_cmd.op == SCP_OP_READ &&
           i_cmd.offset == 8'h19)
      |=> o_rsp_valid && o_rsp_data == $past(i_cmd.data, 2))
    else $error("read after write returned wrong value");
  a_allowed_flag: assert property ( // [R5]
    o_meas_allowed == (chl != 8'h00))
    else $error("measurement allowed flag out of step");
  a_freeze_ce: assert property (
    !i_ce |=> $stable(o_bus_address) && $stable(l12) && !$rose(o_rsp_valid))
    else $error("state moved while clock enable low");

  c_adopt: cover property (
    i_ce && i_cmd_valid && i_cmd.op == SCP_OP_ADOPT);
  c_read_led: cover property (
    i_ce && i_cmd_valid && i_cmd.op == SCP_OP_READ && i_cmd.offset == 8'h02);
  c_all_leds: cover property (o_led.prox_two_led_field == 3'h7);
  c_allowed: cover property ($rose(o_meas_allowed));

endmodule
`default_nettype wire
